// file: common/in_ep_regs.svh
/*
  constants for the in endpoint low control register block: bus offsets,
  field positions, reset values. assumes inclusion by bare name.
*/
// Notes on behaviour
// - bit 7 reads zero, writes to it are ignored.
// - writing 1 to bit 6 clears data toggle; bit reads zero.
// - sending stall sets stall sent flag and clears in packet ready.
// - while stall request is set, every in token gets stall.
// - iso mode: zero length packet on in token sets underrun flag.
// - register at usb address 0x11, resets to all zeros.
// - in packet ready clears on transmit, free double buffer slot; reads zero during iso deferral.
// - fifo not empty reads 1 while fifo holds a packet.
// - flush while fifo not empty raises endpoint interrupt.
// - bulk mode: nak sets underrun flag, firmware clears it.
`ifndef IN_EP_REGS_SVH
`define IN_EP_REGS_SVH
// ==========================================
// register byte addresses
`define USB_ADDR_CTRL_LOW 8'h11
`define OFF_CTRL_LOW 12'h044
`define OFF_CTRL_HIGH 12'h048
`define OFF_IRQ_STATUS 12'h04c
`define OFF_IRQ_MASK 12'h050
// ==========================================
// field positions
`define BIT_TOGGLE_CLEAR 6
`define BIT_STALL_SENT 5
`define BIT_STALL_REQ 4
`define BIT_FLUSH 3
`define BIT_UNDERRUN 2
`define BIT_FIFO_NE 1
`define BIT_IN_RDY 0
`define BIT_HI_DBUF 7
`define BIT_HI_ISO 6
`define BIT_HI_ISOUD 0
`define CTRL_RESET 8'h00
`define CTRL_SW_MASK 8'h3d
// interrupt status bits
`define IRQ_SENT 0
`define IRQ_FLUSH 1
`define IRQ_STALL 2
`define IRQ_WIDTH 3
`endif

// file: common/in_ep_pkg.sv
/*
  types for the in endpoint block. assumes nothing else.
*/
package in_ep_pkg;
  // ==========================================
  // token answers
  typedef enum logic [1:0] {ANS_NONE, ANS_DATA, ANS_ZLP, ANS_STALL} ans_kind_e;
  typedef enum logic [1:0] {ANS_NAK_H, ANS_ACKD, ANS_IDLE_H, ANS_SENT} ans_unused_e;
  // link events from the usb engine
  typedef struct packed
  {
    logic in_token;
    logic host_ack;
    logic sof;
  } link_evt_s;
  typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} tok_state_e;
endpackage

// file: src/pkt_counter.sv
/*
  counts queued packets in the endpoint fifo. assumes one event per cycle max
  of each kind; load and drop may coincide.
*/
`timescale 1ns/1ps
module pkt_counter
  import in_ep_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events
  input wire logic load,
  input wire logic drop,
  // status
  output logic [1:0] count,
  output logic not_empty
);
  logic [1:0] count_q;
  logic do_load;
  logic do_drop;
  assign do_drop = drop && (count_q != 2'h0);
  assign do_load = load && (count_q != 2'(DEPTH));
  // ==========================================
  // packet count update
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count_q <= 2'h0;
    else if (do_load && !do_drop)
      count_q <= count_q + 2'h1;
    else if (do_drop && !do_load)
      count_q <= count_q - 2'h1;
  end
  assign count = count_q;
  assign not_empty = (count_q != 2'h0);
endmodule // pkt_counter

// file: src/in_ep_ctrl.sv
/*
  in endpoint low control register with ahb-lite slave, token answer logic
  and interrupt. assumes single word transfers and one endpoint selected.
*/
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "in_ep_regs.svh"
module in_ep_ctrl
  import in_ep_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // usb engine side
  input wire link_evt_s link_evt,
  input wire logic fifo_load,
  output logic [1:0] answer,
  output logic answer_valid,
  output logic data_toggle,
  // interrupt
  output logic irq
);
  logic wr_pend_q;
  logic [11:0] addr_q;
  logic [31:0] hrdata_q;
  logic [7:0] ctrl_q;
  logic [7:0] high_q;
  logic [`IRQ_WIDTH-1:0] stat_q;
  logic [`IRQ_WIDTH-1:0] mask_q;
  logic toggle_q;
  logic [1:0] answer_q;
  logic answer_valid_q;
  logic irq_q;
  logic iso_hold_q;
  logic wr_ctrl;
  logic wr_high;
  logic wr_mask;
  logic rd_stat;
  logic [7:0] wd;
  logic flush_drop;
  logic sent_drop;
  logic [1:0] pkt_count;
  logic fifo_ne;
  logic tok;
  logic stall_now;
  logic zlp_now;
  logic data_now;
  logic nak_now;
  logic flush_req;
  logic [7:0] ctrl_rd;
  logic addr_phase;
  // ==========================================
  // bus address phase capture
  assign addr_phase = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        addr_q <= haddr;
    end
  end
  assign wd = hwdata[7:0];
  assign wr_ctrl = wr_pend_q && (addr_q == `OFF_CTRL_LOW);
  assign wr_high = wr_pend_q && (addr_q == `OFF_CTRL_HIGH);
  assign wr_mask = wr_pend_q && (addr_q == `OFF_IRQ_MASK);
  assign rd_stat = addr_phase && !hwrite && (haddr == `OFF_IRQ_STATUS);
  // bit 7 and toggle clear read zero
  assign ctrl_rd = {2'b00, ctrl_q[5:2], fifo_ne, ctrl_q[`BIT_IN_RDY] & ~iso_hold_q};
  // ==========================================
  // read data, registered in the address phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_q <= 32'h0;
    else if (addr_phase && !hwrite)
    begin
      if (haddr == `OFF_CTRL_LOW)
        hrdata_q <= {24'h0, ctrl_rd};
      else if (haddr == `OFF_CTRL_HIGH)
        hrdata_q <= {24'h0, high_q};
      else if (haddr == `OFF_IRQ_STATUS)
        hrdata_q <= {29'h0, stat_q};
      else if (haddr == `OFF_IRQ_MASK)
        hrdata_q <= {29'h0, mask_q};
      else
        hrdata_q <= 32'h0;
    end
  end
  assign hrdata = hrdata_q;
  // zero wait states: every transfer ends after one data phase,
  // so the master never stalls and the response is always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ==========================================
  // token answer selection
  assign tok = link_evt.in_token;
  assign stall_now = tok && ctrl_q[`BIT_STALL_REQ];
  // data goes out whenever a packet is queued and no stall is requested; while ready is set,
  // an iso deferral holds the packet back until the next frame start
  // no packet: iso answers with a zero length packet, bulk with a nak
  assign data_now = tok && !stall_now && fifo_ne && ctrl_q[`BIT_IN_RDY] == 1'b0 || tok && !stall_now && fifo_ne && !iso_hold_q && ctrl_q[`BIT_IN_RDY];
  assign zlp_now = tok && !stall_now && !data_now && high_q[`BIT_HI_ISO];
  assign nak_now = tok && !stall_now && !data_now && !high_q[`BIT_HI_ISO];
  // flush acts in the data phase, one packet per write
  assign flush_req = wr_ctrl && wd[`BIT_FLUSH];
  assign flush_drop = flush_req && fifo_ne;
  assign sent_drop = data_now;
  pkt_counter #(.DEPTH(DEPTH)) u_cnt
  (
    .clk(clk),
    .nrst(nrst),
    .load(fifo_load),
    .drop(flush_drop | sent_drop),
    .count(pkt_count),
    .not_empty(fifo_ne)
  );
  // ==========================================
  // low control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= `CTRL_RESET;
    else
    begin
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~`CTRL_SW_MASK) | (wd & `CTRL_SW_MASK);
      ctrl_q[`BIT_FLUSH] <= 1'b0;
      ctrl_q[`BIT_FIFO_NE] <= 1'b0;
      ctrl_q[7:6] <= 2'b00;
      // stall sets flag, only firmware clears
      if (stall_now)
      begin
        ctrl_q[`BIT_STALL_SENT] <= 1'b1;
        ctrl_q[`BIT_IN_RDY] <= 1'b0;
      end
      // underrun on zlp or nak, set wins
      if (zlp_now || nak_now)
        ctrl_q[`BIT_UNDERRUN] <= 1'b1;
      // ready clears on send or free double buffer slot
      if (data_now || (high_q[`BIT_HI_DBUF] && ctrl_q[`BIT_IN_RDY] && pkt_count < 2'(DEPTH)))
        ctrl_q[`BIT_IN_RDY] <= 1'b0;
    end
  end
  // ==========================================
  // high control copy, iso deferral and toggle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_q <= 8'h00;
      iso_hold_q <= 1'b0;
      toggle_q <= 1'b0;
    end
    else
    begin
      if (wr_high)
        high_q <= wd;
      if (link_evt.sof)
        iso_hold_q <= 1'b0;
      else if (wr_ctrl && wd[`BIT_IN_RDY] && high_q[`BIT_HI_ISO] && high_q[`BIT_HI_ISOUD])
        iso_hold_q <= 1'b1;
      if (wr_ctrl && wd[`BIT_TOGGLE_CLEAR])
        toggle_q <= 1'b0;
      else if (link_evt.host_ack)
        toggle_q <= ~toggle_q;
    end
  end
  // ==========================================
  // answer outputs and interrupt
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      answer_q <= ANS_NONE;
      answer_valid_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      answer_valid_q <= tok;
      if (stall_now)
        answer_q <= ANS_STALL;
      else if (data_now)
        answer_q <= ANS_DATA;
      else if (zlp_now)
        answer_q <= ANS_ZLP;
      else if (tok)
        answer_q <= ANS_NONE;
      if (wr_mask)
        mask_q <= wd[`IRQ_WIDTH-1:0];
      // events set sticky bits, set wins over read clear
      stat_q <= (rd_stat ? '0 : stat_q) | {stall_now, flush_drop, data_now};
      irq_q <= |(stat_q & mask_q);
    end
  end
  assign answer = answer_q;
  assign answer_valid = answer_valid_q;
  assign data_toggle = toggle_q;
  assign irq = irq_q;
endmodule // in_ep_ctrl

// file: verif/in_ep_ctrl_sva.sv
/* checker for in_ep_ctrl ports. assumes bind below. */
`timescale 1ns/1ps
module in_ep_ctrl_sva
  import in_ep_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire link_evt_s link_evt,
  input wire logic [1:0] answer,
  input wire logic answer_valid,
  input wire logic data_toggle
);
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_low(w);
    hsel && hready && htrans[1] && hwrite == w && haddr == 12'h044;
  endsequence
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_valid; link_evt.in_token |=> answer_valid; endproperty
  a_valid: assert property (p_valid) else $error("token unanswered");
  property p_novalid; !link_evt.in_token |=> !answer_valid; endproperty
  a_novalid: assert property (p_novalid) else $error("stray answer");
  property p_hold; !answer_valid |-> $stable(answer); endproperty
  a_hold: assert property (p_hold) else $error("answer moved");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_top; s_low(0) |=> hrdata[7:6] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("bit 7 or 6 read high");
  property p_clr; s_low(1) ##1 hwdata[6] |=> !data_toggle; endproperty
  a_clr: assert property (p_clr) else $error("toggle not cleared");
endmodule // in_ep_ctrl_sva
bind in_ep_ctrl in_ep_ctrl_sva chk_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .hreadyout, .hresp, .link_evt, .answer, .answer_valid, .data_toggle);

// file: verif/usb_host_model.sv
/* host side: in tokens and acks. assumes bench requests. */
`timescale 1ns/1ps
module usb_host_model
  import in_ep_pkg::*;
(
  // control
  input wire logic clk,
  input wire logic nrst,
  input wire logic tok_req,
  input wire logic [3:0] slow,
  // link
  input wire logic [1:0] answer,
  input wire logic answer_valid,
  output link_evt_s link_evt
);
  logic [4:0] ack_q;
  // token pulse, ack after data, delay set by slow
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_evt <= '0;
      ack_q <= 5'h0;
    end
    else
    begin
      link_evt.in_token <= tok_req;
      link_evt.sof <= 1'b0;
      link_evt.host_ack <= ack_q == 5'h1;
      if (answer_valid && answer == ANS_DATA)
        ack_q <= {1'b0, slow} + 5'h1;
      else if (ack_q != 5'h0)
        ack_q <= ack_q - 5'h1;
    end
  end
endmodule // usb_host_model

// file: verif/usb_in_endpoint_ctrl_low_tb_top.sv
/* bench for in_ep_ctrl. assumes host model and checker. */
`timescale 1ns/1ps
module usb_in_endpoint_ctrl_low_tb_top
  import in_ep_pkg::*;
;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, tok = 0, fld = 0;
  logic hreadyout, hresp, answer_valid, data_toggle, irq;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0, answer;
  logic [2:0] hsize = 0;
  logic [3:0] slow = 0;
  logic [31:0] hwdata = 0, hrdata, r, lfsr = 32'hcd92;
  link_evt_s evt;
  int miscompares = 0, n_compared = 0;
  in_ep_ctrl #(.DEPTH(2)) dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_evt(evt), .fifo_load(fld), .answer(answer),
    .answer_valid(answer_valid), .data_toggle(data_toggle), .irq(irq));
  usb_host_model host_u (.clk(clk), .nrst(nrst), .tok_req(tok), .slow(slow), .answer(answer),
    .answer_valid(answer_valid), .link_evt(evt));
  initial forever #20 clk = ~clk;
  // ==========
  // tasks
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task rdy;
    int n;
    @(posedge clk);
    for (n = 1; hreadyout !== 1'b1 && n < 64; n++) @(posedge clk);
    if (n >= 64)
    begin
      miscompares++;
      results;
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    rdy;
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task token(input logic [1:0] e);
    int n;
    tok <= 1;
    @(posedge clk);
    tok <= 0;
    for (n = 0; answer_valid !== 1'b1 && n < 8; n++) @(posedge clk);
    if (n >= 8)
    begin
      chk("answer_valid", 1, 0);
      results;
    end
    chk("answer", {30'h0, e}, {30'h0, answer});
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    bus(0, 12'h044, 0);
    chk("low", 0, r);
    repeat (4)
    begin
      lfsr = nxt(lfsr);
      bus(1, 12'h050, lfsr);
      bus(0, 12'h050, 0);
      chk("mask", lfsr & 32'h7, r);
    end
    bus(1, 12'h050, 32'h7);
    bus(1, 12'h044, 32'hd0);
    bus(0, 12'h044, 0);
    chk("low", 32'h10, r);
    token(ANS_STALL);
    bus(0, 12'h044, 0);
    chk("low", 32'h30, r);
    bus(1, 12'h044, 0);
    bus(0, 12'h044, 0);
    chk("low", 0, r);
    bus(0, 12'h04c, 0);
    chk("status", 32'h4, r);
    fld <= 1;
    repeat (2) @(posedge clk);
    fld <= 0;
    bus(0, 12'h044, 0);
    chk("low", 32'h2, r);
    bus(1, 12'h044, 32'h8);
    bus(0, 12'h044, 0);
    chk("low", 32'h2, r);
    chk("irq", 1, irq);
    bus(1, 12'h044, 32'h8);
    bus(0, 12'h044, 0);
    chk("low", 0, r);
    bus(0, 12'h04c, 0);
    chk("status", 32'h2, r);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    fld <= 1;
    slow <= 4'h6;
    @(posedge clk);
    fld <= 0;
    bus(1, 12'h044, 1);
    token(ANS_DATA);
    repeat (12) @(posedge clk);
    bus(0, 12'h044, 0);
    chk("low", 0, r);
    chk("toggle", 1, data_toggle);
    bus(1, 12'h044, 32'h40);
    @(posedge clk);
    chk("toggle", 0, data_toggle);
    token(ANS_NONE);
    bus(0, 12'h044, 0);
    chk("low", 32'h4, r);
    bus(1, 12'h044, 0);
    bus(1, 12'h048, 32'h40);
    token(ANS_ZLP);
    bus(0, 12'h044, 0);
    chk("low", 32'h4, r);
    bus(1, 12'h0f0, 32'hff);
    bus(0, 12'h0f0, 0);
    chk("unmapped", 0, r);
    results;
  end
endmodule // usb_in_endpoint_ctrl_low_tb_top
